// file: verilog/tds_sequencer.sv
/*
  Front-panel sequencer of a magnetically levitated pump drive:
  lamp test, start delay, acceleration, normal, overload, braking,
  fault, mains loss, bar display, heater and backing-pump outputs.
  Assumes all inputs synchronous to clk_i; speed and load arrive as
  percent of target from the analog drive.
*/
`timescale 1ns/100ps
module tds_sequencer #(
  parameter int unsigned TICK_CYCLES = tds_pkg::TICK_CYC,
  parameter int unsigned NSEG        = 10,
  parameter logic [6:0]  MIN_PCT     = 7'h3c,
  parameter logic [6:0]  TOUCH_PCT   = 7'h0a
) (
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic            ce_i,
  input  wire logic            key_start_i,
  input  wire logic            key_stop_i,
  input  wire logic            key_heat_i,
  input  wire logic            remote_i,
  input  wire logic            remote_start_i,
  input  wire logic            remote_stop_n_i,
  input  wire logic            remote_heat_i,
  input  wire logic [8:0]      delay_s_i,
  input  wire logic [6:0]      speed_pct_i,
  input  wire logic [6:0]      load_pct_i,
  input  wire logic            standstill_i,
  input  wire logic            mains_ok_i,
  input  wire logic            overtemp_i,
  input  wire logic            cable_fault_i,
  input  wire logic            pump_mismatch_i,
  output logic                 lamp_power_o,
  output logic                 lamp_start_o,
  output logic                 lamp_stop_o,
  output logic                 lamp_normal_o,
  output logic                 lamp_overload_o,
  output logic                 lamp_fault_o,
  output logic                 lamp_heat_o,
  output logic      [NSEG-1:0] bar_o,
  output logic                 backing_pump_output_o,
  output logic                 vent_valve_o,
  output logic                 heater_o,
  output logic                 motor_run_o,
  output logic                 motor_brake_o,
  output logic                 speed_reduce_o,
  output logic                 generator_mode_o,
  output logic                 bearing_supply_o,
  output logic                 unplug_unsafe_lamp_o
);

  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Prescaler and blink
  logic [PW-1:0]            presc_ff;
  logic                     tick_ff;
  logic [tds_pkg::TW-1:0]   blink_cnt_ff;
  logic                     blink_ff;
  wire presc_end = (presc_ff == PW'(TICK_CYCLES - 1));
  wire blink_end = (blink_cnt_ff == tds_pkg::BLINK_TICKS - 16'h0001);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      presc_ff     <= '0;
      tick_ff      <= 1'b0;
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else if (ce_i) begin
      presc_ff <= presc_end ? '0 : presc_ff + PW'(1);
      tick_ff  <= presc_end;
      if (tick_ff) begin
        blink_cnt_ff <= blink_end ? '0 : blink_cnt_ff + 16'h0001;
        if (blink_end)
          blink_ff <= ~blink_ff;
      end
    end
  end

  // ==========================================================
  // Key conditioning
  logic start_press, stop_press, heat_press;

  tds_key_filter u_key_start (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .tick_i  (tick_ff),
    .key_i   (key_start_i),
    .press_o (start_press)
  );

  tds_key_filter u_key_stop (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .tick_i  (tick_ff),
    .key_i   (key_stop_i),
    .press_o (stop_press)
  );

  tds_key_filter u_key_heat (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .tick_i  (tick_ff),
    .key_i   (key_heat_i),
    .press_o (heat_press)
  );

  // Remote mode disables keys; remote stop beats start for safety
  // stop dominates start
  wire stop_cmd  = remote_i ? ~remote_stop_n_i : stop_press;
  wire start_cmd = remote_i ? (remote_start_i & remote_stop_n_i)
                            : (start_press & ~stop_press);

  // ==========================================================
  // Status decode
  tds_pkg::tds_state_e    state_ff, nxt_state;
  logic [tds_pkg::TW-1:0] timer_ff;
  logic [2:0]             fcode_ff;
  logic                   heat_sel_ff;

  wire cause     = cable_fault_i | pump_mismatch_i;
  wire below95   = (speed_pct_i < tds_pkg::NORMAL_PCT);
  wire below_min = (speed_pct_i < MIN_PCT);
  wire [8:0] delay_clip = (delay_s_i > tds_pkg::DELAY_MAX_S) ?
                          tds_pkg::DELAY_MAX_S : delay_s_i;
  wire [15:0] delay_lim = 16'(16'(delay_clip) * tds_pkg::TICKS_PER_S);
  wire lamp_done  = (timer_ff >= tds_pkg::LAMP_TICKS);
  wire delay_done = (timer_ff >= delay_lim);
  wire accel_done = (timer_ff >= tds_pkg::ACCEL_TICKS);

  // ==========================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tds_pkg::ST_LAMP:
        if (lamp_done)
          nxt_state = tds_pkg::ST_IDLE;
      tds_pkg::ST_IDLE:
        if (start_cmd && !cause)
          nxt_state = (delay_lim == 16'h0000) ? tds_pkg::ST_ACCEL
                                              : tds_pkg::ST_DELAY;
      tds_pkg::ST_DELAY:
        if (cause)
          nxt_state = tds_pkg::ST_FAULT;
        else if (stop_cmd)
          nxt_state = tds_pkg::ST_BRAKE;
        else if (delay_done)
          nxt_state = tds_pkg::ST_ACCEL;
      tds_pkg::ST_ACCEL:
        if (cause)
          nxt_state = tds_pkg::ST_FAULT;
        else if (stop_cmd)
          nxt_state = tds_pkg::ST_BRAKE;
        else if (!below95)
          nxt_state = tds_pkg::ST_NORMAL;
        else if (accel_done)
          nxt_state = below_min ? tds_pkg::ST_FAULT : tds_pkg::ST_OVLD;
      tds_pkg::ST_NORMAL, tds_pkg::ST_OVLD:
        if (cause)
          nxt_state = tds_pkg::ST_FAULT;
        else if (stop_cmd)
          nxt_state = tds_pkg::ST_BRAKE;
        else if (below_min)
          nxt_state = tds_pkg::ST_FAULT;
        else if (overtemp_i)
          nxt_state = tds_pkg::ST_OVLD;
        else if (!below95)
          nxt_state = tds_pkg::ST_NORMAL;
      tds_pkg::ST_BRAKE:
        if (cause)
          nxt_state = tds_pkg::ST_FAULT;
        else if (standstill_i)
          nxt_state = tds_pkg::ST_IDLE;
      tds_pkg::ST_FAULT:
        if (stop_cmd && standstill_i && !cause)
          nxt_state = tds_pkg::ST_IDLE;
      tds_pkg::ST_GEN:
        if (mains_ok_i && standstill_i)
          nxt_state = tds_pkg::ST_IDLE;
      default:
        nxt_state = tds_pkg::ST_IDLE;
    endcase
    if (!mains_ok_i && state_ff != tds_pkg::ST_LAMP)
      nxt_state = tds_pkg::ST_GEN;
  end

  // Fault code latched on entry, lowest-numbered cause first
  wire enter_fault = (nxt_state == tds_pkg::ST_FAULT) &&
                     (state_ff != tds_pkg::ST_FAULT);
  wire [2:0] nxt_fcode = !enter_fault  ? fcode_ff :
                         cable_fault_i ? tds_pkg::FLT_CABLE :
                         pump_mismatch_i ? tds_pkg::FLT_PUMP :
                         tds_pkg::FLT_SPEED;

  // Heat selection: key toggles, remote follows level, local stop clears
  // heat key toggle
  wire nxt_heat_sel = remote_i ? remote_heat_i :
                      stop_cmd ? 1'b0 :
                      heat_press ? ~heat_sel_ff : heat_sel_ff;

  // Interval timer restarts on every state change
  wire [15:0] nxt_timer = (nxt_state != state_ff) ? 16'h0000 :
                          (tick_ff && timer_ff != 16'hffff) ?
                          timer_ff + 16'h0001 : timer_ff;

  // ==========================================================
  // Output decode
  wire s_test   = (state_ff == tds_pkg::ST_LAMP);
  wire s_delay  = (state_ff == tds_pkg::ST_DELAY);
  wire s_accel  = (state_ff == tds_pkg::ST_ACCEL);
  wire s_normal = (state_ff == tds_pkg::ST_NORMAL);
  wire s_ovld   = (state_ff == tds_pkg::ST_OVLD);
  wire s_brake  = (state_ff == tds_pkg::ST_BRAKE);
  wire s_fault  = (state_ff == tds_pkg::ST_FAULT);
  wire s_gen    = (state_ff == tds_pkg::ST_GEN);
  wire s_run    = s_accel | s_normal | s_ovld;

  logic [NSEG-1:0] speed_bar, load_bar;

  tds_bar_meter #(.NSEG(NSEG)) u_bar_speed (
    .value_i (speed_pct_i),
    .seg_o   (speed_bar)
  );

  tds_bar_meter #(.NSEG(NSEG)) u_bar_load (
    .value_i (load_pct_i),
    .seg_o   (load_bar)
  );

  wire nxt_lamp_start  = s_test | (s_delay & blink_ff) | s_accel;
  wire nxt_lamp_stop   = s_test | s_brake;
  wire nxt_lamp_normal = s_test | ((s_accel | s_brake) & blink_ff) |
                         ((s_normal | s_ovld) & (~below95 | blink_ff));
  wire nxt_lamp_ovld   = s_test | s_ovld | (s_run & overtemp_i);
  wire nxt_lamp_fault  = s_test | s_fault;
  wire nxt_lamp_heat   = s_test | (heat_sel_ff & (s_normal | blink_ff));

  wire [NSEG-1:0] fault_bar = (blink_ff && fcode_ff != tds_pkg::FLT_NONE)
                            ? NSEG'(1) << (fcode_ff - 3'h1) : '0;
  wire show_load = s_normal & ~below95;
  wire show_spd  = s_accel | s_ovld | s_brake | s_gen | s_normal;
  wire [NSEG-1:0] nxt_bar = s_test    ? '1 :
                            s_fault   ? fault_bar :
                            show_load ? load_bar :
                            show_spd  ? speed_bar : '0;

  wire nxt_backing = s_delay | s_run | (s_fault & ~standstill_i);
  wire nxt_vent    = s_brake | s_fault | s_gen;
  wire nxt_heater  = heat_sel_ff & s_normal;
  wire nxt_brake   = (s_brake | s_fault) & ~standstill_i;
  wire nxt_reduce  = s_run & overtemp_i;
  wire nxt_bearing = ~(s_gen & (speed_pct_i < TOUCH_PCT));
  wire nxt_unplug  = s_test | ~standstill_i;

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff    <= tds_pkg::ST_LAMP;
      timer_ff    <= '0;
      fcode_ff    <= tds_pkg::FLT_NONE;
      heat_sel_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff    <= nxt_state;
      timer_ff    <= nxt_timer;
      fcode_ff    <= nxt_fcode;
      heat_sel_ff <= nxt_heat_sel;
    end
  end

  // Output registers; power lamp is set from the first enabled edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lamp_power_o          <= 1'b0;
      lamp_start_o          <= 1'b0;
      lamp_stop_o           <= 1'b0;
      lamp_normal_o         <= 1'b0;
      lamp_overload_o       <= 1'b0;
      lamp_fault_o          <= 1'b0;
      lamp_heat_o           <= 1'b0;
      bar_o                 <= '0;
      backing_pump_output_o <= 1'b0;
      vent_valve_o          <= 1'b0;
      heater_o              <= 1'b0;
      motor_run_o           <= 1'b0;
      motor_brake_o         <= 1'b0;
      speed_reduce_o        <= 1'b0;
      generator_mode_o      <= 1'b0;
      bearing_supply_o      <= 1'b1;
      unplug_unsafe_lamp_o  <= 1'b0;
    end else if (ce_i) begin
      lamp_power_o          <= 1'b1;
      lamp_start_o          <= nxt_lamp_start;
      lamp_stop_o           <= nxt_lamp_stop;
      lamp_normal_o         <= nxt_lamp_normal;
      lamp_overload_o       <= nxt_lamp_ovld;
      lamp_fault_o          <= nxt_lamp_fault;
      lamp_heat_o           <= nxt_lamp_heat;
      bar_o                 <= nxt_bar;
      backing_pump_output_o <= nxt_backing;
      vent_valve_o          <= nxt_vent;
      heater_o              <= nxt_heater;
      motor_run_o           <= s_run;
      motor_brake_o         <= nxt_brake;
      speed_reduce_o        <= nxt_reduce;
      generator_mode_o      <= s_gen;
      bearing_supply_o      <= nxt_bearing;
      unplug_unsafe_lamp_o  <= nxt_unplug;
    end
  end

endmodule

// file: inc/tds_pkg.sv
/*
  Constants, state codes and fault codes of the pump drive sequencer.
  Assumes a 100 MHz system clock; every interval is counted in ticks.
*/
// Operation
// - Lamp test two seconds, then power lamp.
// - Start delay selectable zero to five minutes.
// - Start begins acceleration, backing pump on.
// - Start lamp blinks during delay, then steady.
// - Normal lamp blinks, bar shows rising speed.
// - At 95 percent normal steady, start off.
// - Normal run bar shows motor current.
// - Timeout above minimum speed means overload state.
// - Heat key toggles heater, only in normal.
// - Preselected heat lamp blinks during acceleration.
// - Overtemperature reduces speed, lights overload lamp.
// - Below 95 percent show speed, blink normal.
// - Below minimum speed drive off, fault lamp.
// - Stop kills drive, heater, pump; brakes, vents.
// - Braking lights stop, blinks normal lamp.
// - Active braking to standstill, bar shows speed.
// - Fault cleared by stop at standstill only; mains loss also exits it via generator mode to idle.
// - Mains loss: generator mode, bearing supplied down to 10 percent speed.
// - Standstill after stop darkens start, stop, normal.
// - Unplug lamp lit while disconnection unsafe.
// - Fault brakes, steady lamp, blinking coded segment.
// - Remote stop dominates remote start.
package tds_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_MS      = 10;
  localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TW           = 16;
  localparam logic [15:0] TICKS_PER_S  = 16'(1000 / TICK_MS);
  localparam int unsigned LAMP_TEST_MS = 2000;
  localparam logic [15:0] LAMP_TICKS   = 16'(LAMP_TEST_MS / TICK_MS);
  localparam logic [8:0]  DELAY_MAX_S  = 9'h12c;
  localparam int unsigned ACCEL_MAX_S  = 480;
  localparam logic [15:0] ACCEL_TICKS  = 16'(ACCEL_MAX_S * 1000 / TICK_MS);
  localparam int unsigned BLINK_MS     = 250;
  localparam logic [15:0] BLINK_TICKS  = 16'(BLINK_MS / TICK_MS);

  // ==========================================================
  // Speed thresholds in percent of target
  localparam logic [6:0] NORMAL_PCT = 7'h5f;
  localparam int unsigned FULL_PCT  = 100;

  // ==========================================================
  // Fault causes; the flashing segment number is the code minus one
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_CABLE = 3'h1;
  localparam logic [2:0] FLT_PUMP  = 3'h2;
  localparam logic [2:0] FLT_SPEED = 3'h4;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_LAMP   = 4'h0,
    ST_IDLE   = 4'h1,
    ST_DELAY  = 4'h2,
    ST_ACCEL  = 4'h3,
    ST_NORMAL = 4'h4,
    ST_OVLD   = 4'h5,
    ST_BRAKE  = 4'h6,
    ST_FAULT  = 4'h7,
    ST_GEN    = 4'h8
  } tds_state_e;

endpackage

// file: verilog/tds_key_filter.sv
/*
  Key debouncer: samples a key on each tick, needs two equal samples,
  and gives one single-cycle pulse per press.
  Assumes the key input is synchronous to clk_i.
*/
`timescale 1ns/100ps
module tds_key_filter (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic tick_i,
  input  wire logic key_i,
  output logic      press_o
);

  logic [1:0] samp_ff;
  logic       stable_ff;
  logic       press_ff;
  wire        agree    = (samp_ff[0] == samp_ff[1]);
  wire        nxt_rise = tick_i & agree & samp_ff[0] & ~stable_ff;

  // ==========================================================
  // Filter and edge detect
  // debounce and edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      samp_ff   <= 2'h0;
      stable_ff <= 1'b0;
      press_ff  <= 1'b0;
    end else if (ce_i) begin
      press_ff <= nxt_rise;
      if (tick_i) begin
        samp_ff <= {samp_ff[0], key_i};
        if (agree)
          stable_ff <= samp_ff[0];
      end
    end
  end

  assign press_o = press_ff;

endmodule

// file: verilog/tds_bar_meter.sv
/*
  Bar graph encoder: percent value to a thermometer of segments,
  segment 0 at the bottom.
  Assumes value_i is 0 to 100; larger values light every segment.
*/
`timescale 1ns/100ps
module tds_bar_meter #(
  parameter int unsigned NSEG = 10
) (
  input  wire logic [6:0]      value_i,
  output logic      [NSEG-1:0] seg_o
);

  // ==========================================================
  // One comparator per segment
  for (genvar k = 0; k < NSEG; k++) begin : g_seg
    localparam int unsigned TH = (k + 1) * tds_pkg::FULL_PCT / NSEG;
    assign seg_o[k] = (value_i >= 7'(TH));
  end

endmodule

// file: test/tds_sequencer_sva.sv
/*
  Checker of the pump drive sequencer: output relations over time.
  Assumes binding to tds_sequencer with ce_i held high.
*/
`timescale 1ns/100ps
module tds_sequencer_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic remote_i,
  input wire logic remote_stop_n_i,
  input wire logic mains_ok_i,
  input wire logic standstill_i,
  input wire logic lamp_power_o,
  input wire logic lamp_stop_o,
  input wire logic lamp_fault_o,
  input wire logic lamp_heat_o,
  input wire logic backing_pump_output_o,
  input wire logic heater_o,
  input wire logic motor_run_o,
  input wire logic motor_brake_o,
  input wire logic generator_mode_o,
  input wire logic unplug_unsafe_lamp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Lamps and drive outputs
  // power stays lit
  property p_pwr; lamp_power_o |=> lamp_power_o; endproperty
  a_pwr: assert property (p_pwr) else $error("power lamp dropped");
  property p_fore; $rose(motor_run_o) |-> backing_pump_output_o; endproperty
  a_fore: assert property (p_fore) else $error("no backing pump");
  property p_heat; heater_o |-> lamp_heat_o && motor_run_o; endproperty
  a_heat: assert property (p_heat) else $error("heater misuse");
  property p_flt; lamp_fault_o |-> !motor_run_o && !heater_o; endproperty
  a_flt: assert property (p_flt) else $error("drive in fault");
  property p_brk; motor_brake_o |-> !motor_run_o && !heater_o; endproperty
  a_brk: assert property (p_brk) else $error("drive while braking");
  property p_stl; motor_brake_o && !lamp_fault_o |-> lamp_stop_o; endproperty
  a_stl: assert property (p_stl) else $error("stop lamp dark");
  property p_gen; $fell(mains_ok_i) && motor_run_o |-> ##[1:3]
    generator_mode_o; endproperty
  a_gen: assert property (p_gen) else $error("no generator mode");
  property p_unp; !standstill_i ##1 !standstill_i |-> unplug_unsafe_lamp_o;
  endproperty
  a_unp: assert property (p_unp) else $error("unplug lamp dark");
  property p_rst; remote_i && !remote_stop_n_i && motor_run_o
    |-> ##[1:3] !motor_run_o; endproperty
  a_rst: assert property (p_rst) else $error("remote stop ignored");
  // Main scenarios reached
  c_gen: cover property (generator_mode_o);
  c_flt: cover property (lamp_fault_o && motor_brake_o);
  c_end: cover property ($fell(motor_brake_o) && standstill_i);
endmodule

// file: test/tds_pump_model.sv
/*
  Behavioural rotor: speed follows the drive up to a ceiling.
  Assumes the sequencer drive output on the same clock.
*/
`timescale 1ns/100ps
module tds_pump_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       motor_run_i,
  input  wire logic       hold_i,
  input  wire logic [6:0] cap_i,
  output logic      [6:0] speed_pct_o,
  output logic      [6:0] load_pct_o,
  output logic            standstill_o
);
  logic [2:0] step_ff;
  logic [6:0] speed_ff;
  // ==========================================================
  // Rotor: one percent per eight clocks, hold freezes for sampling
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      step_ff  <= 3'h0;
      speed_ff <= 7'h00;
    end else begin
      step_ff <= step_ff + 3'h1;
      if (step_ff == 3'h7 && !hold_i) begin
        if (motor_run_i && speed_ff < cap_i) begin
          speed_ff <= speed_ff + 7'h01;
        end else if (speed_ff != 7'h00 &&
                     (!motor_run_i || speed_ff > cap_i)) begin
          speed_ff <= speed_ff - 7'h01;
        end
      end
    end
  end
  // Load rises with speed; no load reading beyond half scale
  assign speed_pct_o  = speed_ff;
  assign load_pct_o   = speed_ff >> 1;
  assign standstill_o = (speed_ff == 7'h00);
endmodule

// file: test/tds_sequencer_bench.sv
/*
  Self-checking bench of tds_sequencer with the rotor model.
  Assumes a 100 MHz clock and a 4-cycle tick to keep runs short.
*/
`timescale 1ns/100ps
module tds_sequencer_bench;
  logic       clk_i = 1'b0, reset_i = 1'b1, hold = 1'b0;
  logic       key_start_i = 1'b0, key_stop_i = 1'b0, key_heat_i = 1'b0;
  logic       remote_i = 1'b0, remote_start_i = 1'b0, remote_stop_n_i = 1'b1;
  logic       mains_ok_i = 1'b1, overtemp_i = 1'b0, remote_heat_i = 1'b0;
  logic       cable_fault_i = 1'b0, pump_mismatch_i = 1'b0;
  logic [8:0] delay_s_i = 9'h001;
  logic [6:0] cap = 7'h64, speed_pct_i, load_pct_i;
  logic       standstill_i, lamp_power_o, lamp_start_o, lamp_stop_o;
  logic       lamp_normal_o, lamp_overload_o, lamp_fault_o, lamp_heat_o;
  logic       backing_pump_output_o, vent_valve_o, heater_o, motor_run_o;
  logic       motor_brake_o, speed_reduce_o, generator_mode_o;
  logic       bearing_supply_o, unplug_unsafe_lamp_o;
  logic [9:0] bar_o;
  int         n_mismatch = 0, compares = 0, cyc = 0;
  wire logic [9:0] obs = {lamp_stop_o, lamp_heat_o, generator_mode_o,
    bearing_supply_o, lamp_fault_o, lamp_start_o, motor_run_o,
    standstill_i, lamp_normal_o, motor_brake_o};

  tds_sequencer #(.TICK_CYCLES(4)) dut (.clk_i, .reset_i, .ce_i(1'b1),
    .key_start_i, .key_stop_i, .key_heat_i, .remote_i, .remote_start_i,
    .remote_stop_n_i, .remote_heat_i, .delay_s_i, .speed_pct_i,
    .load_pct_i, .standstill_i, .mains_ok_i, .overtemp_i, .cable_fault_i,
    .pump_mismatch_i, .lamp_power_o, .lamp_start_o, .lamp_stop_o,
    .lamp_normal_o, .lamp_overload_o, .lamp_fault_o, .lamp_heat_o, .bar_o,
    .backing_pump_output_o, .vent_valve_o, .heater_o, .motor_run_o,
    .motor_brake_o, .speed_reduce_o, .generator_mode_o, .bearing_supply_o,
    .unplug_unsafe_lamp_o);
  tds_pump_model pump (.clk_i, .reset_i, .motor_run_i(motor_run_o),
    .hold_i(hold), .cap_i(cap), .speed_pct_o(speed_pct_i),
    .load_pct_o(load_pct_i), .standstill_o(standstill_i));

  // ==========================================================
  // Clock, watchdog and shared tasks
  always #5 clk_i = ~clk_i;
  // Ceiling well above the roughly 10k cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude;
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Checks happen at falling edges, clear of the launching edge
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Five ticks high, five low: one clean press per call
  task automatic press(input int k);
    @(posedge clk_i) begin
      key_start_i <= (k == 0);
      key_stop_i  <= (k == 1);
      key_heat_i  <= (k == 2);
    end
    tk(20);
    @(posedge clk_i) {key_start_i, key_stop_i, key_heat_i} <= 3'h0;
    tk(20);
  endtask
  task automatic wt(input int b, input logic v, input int lim);
    for (int i = 0; i < lim && obs[b] !== v; i++) tk(1);
    chk(10'(obs[b]), 10'(v));
  endtask
  task automatic blink(input int b);
    logic s0 = 1'b0, s1 = 1'b0;
    for (int i = 0; i < 240; i++) begin
      tk(1);
      s0 |= (obs[b] === 1'b0);
      s1 |= (obs[b] === 1'b1);
    end
    chk({8'h00, s0, s1}, 10'h003);
  endtask
  function automatic logic [9:0] therm(input logic [6:0] v);
    therm = 10'h000;
    for (int k = 0; k < 10; k++) therm[k] = (v >= 7'((k + 1) * 10));
  endfunction
  // Freeze the rotor so the bar has settled on a known speed
  task automatic bar_speed;
    @(posedge clk_i) hold <= 1'b1;
    tk(6);
    chk(bar_o, therm(speed_pct_i));
    @(posedge clk_i) hold <= 1'b0;
  endtask
  task automatic rstart;
    @(posedge clk_i) remote_start_i <= 1'b1;
    tk(3);
    @(posedge clk_i) remote_start_i <= 1'b0;
    wt(3, 1'b1, 20);
  endtask
  // Fault codes 1, 2 and 4 flash segment code-1
  task automatic run_fault(input int c);
    logic on = 1'b0, bad = 1'b0;
    rstart();
    @(posedge clk_i) remote_heat_i <= 1'b1;
    tk(900);
    chk(10'(heater_o), 10'h001);
    @(posedge clk_i) begin
      cable_fault_i   <= (c == 1);
      pump_mismatch_i <= (c == 2);
      if (c == 4) cap <= 7'h28;
    end
    wt(5, 1'b1, 600);
    chk(10'({motor_run_o, motor_brake_o}), 10'h001);
    for (int i = 0; i < 240; i++) begin
      tk(1);
      on |= (bar_o === (10'h001 << (c - 1)));
      bad |= (bar_o !== (10'h001 << (c - 1)) && bar_o !== 10'h000);
    end
    chk({8'h00, on, bad}, 10'h002);
    @(posedge clk_i) {cable_fault_i, pump_mismatch_i, remote_stop_n_i} <= 3'h0;
    tk(3);
    @(posedge clk_i) remote_stop_n_i <= 1'b1;
    tk(4);
    chk(10'(lamp_fault_o), 10'h001);
    wt(2, 1'b1, 1200);
    @(posedge clk_i) remote_stop_n_i <= 1'b0;
    tk(3);
    @(posedge clk_i) {remote_stop_n_i, cap} <= {1'b1, 7'h64};
    tk(4);
    chk(10'(lamp_fault_o), 10'h000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    tk(6);
    @(posedge clk_i) reset_i <= 1'b0;
    tk(100);
    chk(bar_o, 10'h3ff);
    chk(10'({lamp_start_o, lamp_fault_o,
      unplug_unsafe_lamp_o}), 10'h007);
    tk(850);
    chk(10'({lamp_power_o, lamp_start_o, lamp_fault_o}), 10'h004);
    // Keys are dead while remote is selected
    @(posedge clk_i) remote_i <= 1'b1;
    press(0);
    chk(10'(backing_pump_output_o), 10'h000);
    @(posedge clk_i) remote_i <= 1'b0;
    press(0);
    chk(10'({backing_pump_output_o, motor_run_o}), 10'h002);
    blink(4);
    wt(3, 1'b1, 600);
    chk(10'(lamp_start_o), 10'h001);
    blink(1);
    bar_speed();
    press(2);
    blink(8);
    chk(10'(heater_o), 10'h000);
    wt(4, 1'b0, 1000);
    chk(10'({lamp_normal_o, heater_o, lamp_heat_o}), 10'h007);
    tk(60);
    chk(bar_o, therm(load_pct_i));
    press(2);
    chk(10'({heater_o, lamp_heat_o}), 10'h000);
    press(2);
    chk(10'({heater_o, lamp_heat_o}), 10'h003);
    @(posedge clk_i) cap <= 7'h50;
    tk(200);
    bar_speed();
    blink(1);
    @(posedge clk_i) overtemp_i <= 1'b1;
    tk(4);
    chk(10'({speed_reduce_o, lamp_overload_o}), 10'h003);
    @(posedge clk_i) {overtemp_i, cap} <= {1'b0, 7'h64};
    tk(200);
    press(1);
    chk(10'({motor_run_o, motor_brake_o, backing_pump_output_o, vent_valve_o,
      heater_o, lamp_stop_o}), 10'h015);
    blink(1);
    bar_speed();
    wt(2, 1'b1, 1200);
    tk(4);
    chk(10'({lamp_start_o, lamp_stop_o, lamp_normal_o}), 10'h000);
    chk(10'(unplug_unsafe_lamp_o), 10'h000);
    // Remote mode: faults, stop dominance, mains loss
    @(posedge clk_i) {remote_i, delay_s_i} <= {1'b1, 9'h000};
    run_fault(1);
    run_fault(2);
    run_fault(4);
    @(posedge clk_i) {remote_start_i, remote_stop_n_i} <= 2'h2;
    tk(20);
    chk(10'({motor_run_o, backing_pump_output_o}), 10'h000);
    @(posedge clk_i) {remote_start_i, remote_stop_n_i} <= 2'h1;
    rstart();
    tk(50);
    @(posedge clk_i) remote_stop_n_i <= 1'b0;
    wt(3, 1'b0, 10);
    wt(2, 1'b1, 800);
    @(posedge clk_i) remote_stop_n_i <= 1'b1;
    rstart();
    tk(300);
    @(posedge clk_i) mains_ok_i <= 1'b0;
    wt(7, 1'b1, 10);
    chk(10'(bearing_supply_o), 10'h001);
    wt(6, 1'b0, 1000);
    chk(10'(speed_pct_i < 7'h0a), 10'h001);
    @(posedge clk_i) mains_ok_i <= 1'b1;
    wt(2, 1'b1, 200);
    tk(10);
    chk(10'(generator_mode_o), 10'h000);
    conclude();
  end
endmodule

bind tds_sequencer tds_sequencer_sva u_sva (.clk_i, .reset_i, .remote_i,
  .remote_stop_n_i, .mains_ok_i, .standstill_i, .lamp_power_o, .lamp_stop_o,
  .lamp_fault_o, .lamp_heat_o, .backing_pump_output_o, .heater_o,
  .motor_run_o, .motor_brake_o, .generator_mode_o, .unplug_unsafe_lamp_o);
